// ==== src/sched_regs_pkg.sv ====
// Package: offsets, fields, reset values and sizes of the scheduler register bank
package sched_regs_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_THRESH = 12'hf10;
  localparam logic [11:0] OFF_WEIGHT = 12'hf14;
  localparam logic [11:0] OFF_CNT1 = 12'hf18;
  localparam logic [11:0] OFF_CNT2 = 12'hf1c;
  localparam logic [11:0] OFF_CNT3 = 12'hf20;
  localparam logic [11:0] OFF_CNT6 = 12'hf2c;
  localparam logic [11:0] OFF_INJECT = 12'hf30;
  // Threshold fields
  localparam int THR_W = 11;
  localparam int RESUME_LSB = 0;
  localparam int PAUSE_LSB = 16;
  localparam logic [10:0] THR_RESET = 11'h7ff;
  // Weight fields: one nibble per queue, top bit reserved
  localparam int NQ = 8;
  localparam int WGT_W = 3;
  localparam int WGT_STRIDE = 4;
  localparam logic [2:0] WGT_RESET = 3'h0;
  // Counters
  localparam int CNT_W = 8;
  localparam int NCNT = 13;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // Counter index map
  localparam int CI_TLPID0 = 9;
  localparam int CI_TLPID1 = 10;
  localparam int CI_SQLL = 11;
  localparam int CI_RETRY = 12;
  // Injection bits
  localparam int INJ_W = 6;
  localparam int INJ_SINGLE = 0;
  localparam int INJ_DOUBLE = 1;
  localparam int INJ_FIELD = 2;
  localparam int INJ_STRIDE = 3;
  localparam logic [5:0] INJ_RESET = 6'h00;
  // TLP count width
  localparam int TLPC_W = 11;
endpackage

// ==== src/soft_err_counter.sv ====
// Saturating 8-bit soft-error counter
`timescale 1ns/100ps
module soft_err_counter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Event and value
  input wire logic corr_i,
  output logic [sched_regs_pkg::CNT_W-1:0] count_o
);
  import sched_regs_pkg::*;
  logic [CNT_W-1:0] cnt_q, cnt_d;

  // Count corrected errors, stick at the top rather than wrap back to zero
  always_comb begin
    cnt_d = cnt_q;
    if (corr_i && cnt_q != CNT_MAX) begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count_o = cnt_q;

  AST_CNT_SAT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cnt_q == CNT_MAX) |=> (cnt_q == CNT_MAX))
    else $error("Counter wrapped past maximum");
  AST_CNT_INC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (corr_i && cnt_q != CNT_MAX) |=> (cnt_q == $past(cnt_q) + 8'h01))
    else $error("Counter missed a corrected error");
endmodule // soft_err_counter

// ==== src/burst_sched.sv ====
// Per-queue burst scheduler: up to weight+1 back-to-back grants while other queues wait
`timescale 1ns/100ps
module burst_sched (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic [sched_regs_pkg::WGT_W-1:0] weight_i,
  input wire logic own_dest_i,
  input wire logic req_i,
  input wire logic others_i,
  input wire logic enable_i,
  input wire logic turn_i,
  // Status
  output logic issue_o,
  output logic yield_o
);
  import sched_regs_pkg::*;
  logic [WGT_W:0] sent_q, sent_d;
  logic [WGT_W:0] limit;

  // Own-destination queue never issues: a port does not send to itself
  assign limit = {1'b0, weight_i} + 4'h1;
  assign issue_o = turn_i && req_i && enable_i && !own_dest_i;
  // Yield when burst is spent and others wait, or when nothing to send
  assign yield_o = turn_i && (!req_i || own_dest_i ||
                   (others_i && (sent_q + 4'h1 >= limit)));

  // Stop counting at the last slot: a lone queue streams without wrapping
  always_comb begin
    sent_d = sent_q;
    if (yield_o) begin
      sent_d = '0;
    end else if (issue_o && (sent_q + 4'h1 < limit)) begin
      sent_d = sent_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sent_q <= '0;
    end else begin
      sent_q <= sent_d;
    end
  end

  AST_BURST_LIMIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sent_q < limit)
    else $error("Burst exceeded programmed weight");
  AST_OWN_SILENT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    own_dest_i |-> !issue_o)
    else $error("Own-destination queue issued");
endmodule // burst_sched

// ==== src/source_sched_regs.sv ====
// Source scheduler weight, thresholds, soft-error counters and injection
`timescale 1ns/100ps
module source_sched_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // Port identity: station-leading ports carry error logic
  input wire logic lead_port_i,
  // Arbitration table reload
  input wire logic load_arb_i,
  input wire logic [31:0] arb_weights_i,
  // Egress TLP count
  input wire logic [sched_regs_pkg::TLPC_W-1:0] tlp_count_i,
  // Source queues
  input wire logic [sched_regs_pkg::NQ-1:0] q_req_i,
  input wire logic [sched_regs_pkg::NQ-1:0] own_dest_i,
  input wire logic [sched_regs_pkg::NQ-1:0] q_turn_i,
  output logic [sched_regs_pkg::NQ-1:0] q_issue_o,
  output logic [sched_regs_pkg::NQ-1:0] q_yield_o,
  output logic sched_enable_o,
  // Corrected-error events from RAM ECC
  input wire logic [sched_regs_pkg::NCNT-1:0] corr_i,
  // Injection requests to link-list RAM instances 0 and 1
  output logic [1:0] inj_single_o,
  output logic [1:0] inj_double_o,
  output logic [1:0] inj_data_sel_o
);
  import sched_regs_pkg::*;

  logic [THR_W-1:0] resume_q, resume_d, pause_q, pause_d;
  logic [NQ*WGT_STRIDE-1:0] wgt_q, wgt_d;
  logic [INJ_W-1:0] inj_q, inj_d;
  logic en_q, en_d;
  logic [1:0] sgl_q, sgl_d, dbl_q, dbl_d;
  logic [NCNT*CNT_W-1:0] cnt;
  logic [NCNT-1:0] corr_g;
  logic [31:0] rdata_q, rdata_d;
  logic wr_thr, wr_wgt, wr_inj;

  assign wr_thr = reg_wr_i && reg_addr_i == OFF_THRESH;
  assign wr_wgt = reg_wr_i && reg_addr_i == OFF_WEIGHT;
  assign wr_inj = reg_wr_i && reg_addr_i == OFF_INJECT && lead_port_i;

  // Threshold and weight registers; reserved weight bits forced to zero
  always_comb begin
    resume_d = resume_q;
    pause_d = pause_q;
    wgt_d = wgt_q;
    if (wr_thr) begin
      resume_d = reg_wdata_i[RESUME_LSB +: THR_W];
      pause_d = reg_wdata_i[PAUSE_LSB +: THR_W];
    end
    // Table reload wins over a register write in the same cycle
    if (load_arb_i) begin
      for (int i = 0; i < NQ; i++) begin
        wgt_d[i*WGT_STRIDE +: WGT_STRIDE] =
          {1'b0, arb_weights_i[i*WGT_STRIDE +: WGT_W]};
      end
    end else if (wr_wgt) begin
      for (int i = 0; i < NQ; i++) begin
        wgt_d[i*WGT_STRIDE +: WGT_STRIDE] =
          {1'b0, reg_wdata_i[i*WGT_STRIDE +: WGT_W]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      resume_q <= THR_RESET;
      pause_q <= THR_RESET;
      wgt_q <= '0;
    end else begin
      resume_q <= resume_d;
      pause_q <= pause_d;
      wgt_q <= wgt_d;
    end
  end

  // Hysteresis gate; a gap between thresholds avoids enable chatter
  always_comb begin
    en_d = en_q;
    if (en_q && tlp_count_i >= pause_q) begin
      en_d = 1'b0;
    end else if (!en_q && tlp_count_i < resume_q) begin
      en_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_q <= 1'b1;
    end else begin
      en_q <= en_d;
    end
  end

  assign sched_enable_o = en_q;

  // One burst scheduler per source queue
  for (genvar g = 0; g < NQ; g++) begin : g_sched
    burst_sched u_sched (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .weight_i(wgt_q[g*WGT_STRIDE +: WGT_W]),
      .own_dest_i(own_dest_i[g]),
      .req_i(q_req_i[g]),
      .others_i(|(q_req_i & ~own_dest_i & ~(8'h01 << g))),
      .enable_i(en_q),
      .turn_i(q_turn_i[g]),
      .issue_o(q_issue_o[g]),
      .yield_o(q_yield_o[g])
    );
  end

  // Counters count only on leading ports; no path loads them
  assign corr_g = corr_i & {NCNT{lead_port_i}};
  for (genvar c = 0; c < NCNT; c++) begin : g_cnt
    soft_err_counter u_cnt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .corr_i(corr_g[c]),
      .count_o(cnt[c*CNT_W +: CNT_W])
    );
  end

  // Injection register; a toggle pulses on any written change of value
  always_comb begin
    inj_d = inj_q;
    if (wr_inj) begin
      inj_d = reg_wdata_i[INJ_W-1:0];
    end
    for (int k = 0; k < 2; k++) begin
      sgl_d[k] = inj_d[k*INJ_STRIDE+INJ_SINGLE] !=
                 inj_q[k*INJ_STRIDE+INJ_SINGLE];
      dbl_d[k] = inj_d[k*INJ_STRIDE+INJ_DOUBLE] !=
                 inj_q[k*INJ_STRIDE+INJ_DOUBLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      inj_q <= INJ_RESET;
      sgl_q <= 2'h0;
      dbl_q <= 2'h0;
    end else begin
      inj_q <= inj_d;
      sgl_q <= sgl_d;
      dbl_q <= dbl_d;
    end
  end

  assign inj_single_o = sgl_q;
  assign inj_double_o = dbl_q;
  // Select is applied with the pulse: 0 check bits, 1 data bits
  assign inj_data_sel_o = {inj_q[INJ_STRIDE+INJ_FIELD],
                           inj_q[INJ_FIELD]};

  // Read mux, registered; unmapped and absent registers read zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      rdata_d = 32'h0000_0000;
      case (reg_addr_i)
        OFF_THRESH: begin
          rdata_d[RESUME_LSB +: THR_W] = resume_q;
          rdata_d[PAUSE_LSB +: THR_W] = pause_q;
        end
        OFF_WEIGHT: rdata_d = wgt_q;
        OFF_CNT1: if (lead_port_i) rdata_d = cnt[0 +: 32];
        OFF_CNT2: if (lead_port_i) rdata_d = cnt[32 +: 32];
        OFF_CNT3: begin
          if (lead_port_i) begin
            rdata_d = {8'h00, cnt[CI_TLPID1*CNT_W +: CNT_W],
                       cnt[CI_TLPID0*CNT_W +: CNT_W], 8'h00};
          end
        end
        OFF_CNT6: begin
          if (lead_port_i) begin
            rdata_d = {cnt[CI_RETRY*CNT_W +: CNT_W],
                       cnt[CI_SQLL*CNT_W +: CNT_W], 16'h0000};
          end
        end
        OFF_INJECT: if (lead_port_i) rdata_d = {26'h0, inj_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // Checks
  sequence s_inj_write0;
    wr_inj && (reg_wdata_i[INJ_SINGLE] != inj_q[INJ_SINGLE]);
  endsequence
  AST_PAUSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (en_q && tlp_count_i >= pause_q) |=> !sched_enable_o)
    else $error("Scheduling not paused at upper threshold");
  AST_RESUME: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!en_q && tlp_count_i >= resume_q) |=> !sched_enable_o)
    else $error("Scheduling resumed above lower threshold");
  AST_WGT_RSVD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wgt_q & 32'h8888_8888) == 32'h0)
    else $error("Reserved weight bit set");
  AST_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    load_arb_i |=> wgt_q == ($past(arb_weights_i) & 32'h7777_7777))
    else $error("Weights not reloaded from table");
  AST_INJ0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_inj_write0 ##1 !wr_inj)
    |-> inj_single_o[0] ##1 !inj_single_o[0])
    else $error("Single-bit injection not one pulse");
  AST_INJ0D: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_inj && reg_wdata_i[INJ_DOUBLE] == inj_q[INJ_DOUBLE])
    |=> !inj_double_o[0])
    else $error("Double-bit injection without a toggle");
  AST_NONLEAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!lead_port_i && reg_rd_i && reg_addr_i == OFF_INJECT)
    |=> reg_rdata_o == 32'h0)
    else $error("Injection register visible on non-leading port");
  AST_INJ1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_inj && reg_wdata_i[INJ_STRIDE] != inj_q[INJ_STRIDE])
    |=> inj_single_o[1])
    else $error("Instance 1 injection missed");
endmodule // source_sched_regs

// ==== sim/testbench.sv ====
// Self-checking testbench for the scheduler register bank
`timescale 1ns/100ps
module testbench;
  import sched_regs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic lead_port_i = 1'b1;
  logic load_arb_i = 1'b0;
  logic [31:0] arb_weights_i = 32'h0;
  logic [TLPC_W-1:0] tlp_count_i = '0;
  logic [NQ-1:0] q_req_i = '0;
  logic [NQ-1:0] own_dest_i = '0;
  logic [NQ-1:0] q_turn_i = '0;
  logic [NQ-1:0] q_issue_o;
  logic [NQ-1:0] q_yield_o;
  logic sched_enable_o;
  logic [NCNT-1:0] corr_i = '0;
  logic [1:0] inj_single_o;
  logic [1:0] inj_double_o;
  logic [1:0] inj_data_sel_o;
  int fails = 0;
  int num_checks = 0;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  source_sched_regs i_source_sched_regs (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .lead_port_i(lead_port_i), .load_arb_i(load_arb_i),
    .arb_weights_i(arb_weights_i), .tlp_count_i(tlp_count_i),
    .q_req_i(q_req_i), .own_dest_i(own_dest_i), .q_turn_i(q_turn_i),
    .q_issue_o(q_issue_o), .q_yield_o(q_yield_o),
    .sched_enable_o(sched_enable_o), .corr_i(corr_i),
    .inj_single_o(inj_single_o), .inj_double_o(inj_double_o),
    .inj_data_sel_o(inj_data_sel_o)
  );

  // Comparison helpers
  task check_word(input string what, input logic [31:0] exp,
                  input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task check_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  // One-cycle strobes, held up to the taking edge
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check_word($sformatf("read %h", a), exp, reg_rdata_o);
  endtask

  // Write the injection register and collect every pulse seen after it
  task inj_step(input logic [31:0] d, input logic [5:0] exp);
    logic [5:0] hit;
    logic [5:0] v;
    int tot;
    hit = '0;
    tot = 0;
    wr(OFF_INJECT, d);
    repeat (4) begin
      #1 v = {1'b0, inj_double_o[1], inj_single_o[1], 1'b0,
              inj_double_o[0], inj_single_o[0]};
      hit |= v;
      tot += $countones(v);
      @(posedge clk_i);
    end
    check_word("inject pulses", {26'h0, exp}, {26'h0, hit});
    check_word("pulse length", 32'($countones(exp)), 32'(tot));
  endtask

  task pulse_corr(input int idx, input int n);
    repeat (n) begin
      @(posedge clk_i);
      corr_i <= NCNT'(1) << idx;
      @(posedge clk_i);
      corr_i <= '0;
    end
  endtask

  // Give queue idx the turn and count issues up to its yield
  task burst(input int idx, input int exp);
    int n;
    n = 0;
    @(posedge clk_i);
    q_turn_i <= NQ'(1) << idx;
    // Sample each granted cycle, the first one included
    for (int c = 0; c < 12; c++) begin
      #1 if (q_issue_o[idx] === 1'b1) n++;
      if (q_yield_o[idx] === 1'b1) break;
      @(posedge clk_i);
    end
    @(posedge clk_i);
    q_turn_i <= '0;
    check_word("burst issues", 32'(exp), 32'(n));
  endtask

  task set_count(input int c);
    @(posedge clk_i);
    tlp_count_i <= TLPC_W'(c);
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task conclude;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Reset values and read-only or unmapped places
    rd_chk(OFF_THRESH, 32'h07ff07ff);
    rd_chk(OFF_WEIGHT, 32'h0);
    rd_chk(OFF_CNT1, 32'h0);
    rd_chk(OFF_INJECT, 32'h0);
    rd_chk(12'hf24, 32'h0);
    check_bit("enable", 1'b1, sched_enable_o);
    wr(OFF_WEIGHT, 32'hffffffff);
    rd_chk(OFF_WEIGHT, 32'h77777777);
    $display("test reset done");
    // Weight reload beats nothing else here; bit 3 of each nibble dropped
    @(posedge clk_i);
    load_arb_i <= 1'b1;
    arb_weights_i <= 32'h12345678;
    @(posedge clk_i);
    load_arb_i <= 1'b0;
    rd_chk(OFF_WEIGHT, 32'h12345670);
    $display("test reload done");
    // Hysteresis between resume 4 and pause 10
    wr(OFF_THRESH, 32'hffffffff);
    rd_chk(OFF_THRESH, 32'h07ff07ff);
    wr(OFF_THRESH, 32'h000a0004);
    set_count(9);
    check_bit("enable at 9", 1'b1, sched_enable_o);
    set_count(10);
    check_bit("enable at 10", 1'b0, sched_enable_o);
    set_count(4);
    check_bit("enable at 4", 1'b0, sched_enable_o);
    set_count(3);
    check_bit("enable at 3", 1'b1, sched_enable_o);
    set_count(0);
    $display("test threshold done");
    // Bursts: queue a weight 0, queue h weight 7, others waiting
    wr(OFF_WEIGHT, 32'h70000000);
    q_req_i <= 8'h83;
    burst(0, 1);
    burst(7, 8);
    own_dest_i <= 8'h01;
    @(posedge clk_i);
    q_turn_i <= 8'h01;
    @(posedge clk_i);
    #1 check_bit("own queue issue", 1'b0, q_issue_o[0]);
    check_bit("own queue yield", 1'b1, q_yield_o[0]);
    @(posedge clk_i);
    q_turn_i <= 8'h00;
    own_dest_i <= 8'h00;
    q_req_i <= 8'h00;
    $display("test burst done");
    // Counters, byte lanes and saturation
    pulse_corr(0, 3);
    pulse_corr(3, 1);
    pulse_corr(4, 2);
    pulse_corr(CI_TLPID0, 1);
    pulse_corr(CI_TLPID1, 5);
    pulse_corr(CI_SQLL, 1);
    pulse_corr(CI_RETRY, 260);
    wr(OFF_CNT1, 32'hffffffff);
    rd_chk(OFF_CNT1, 32'h01000003);
    rd_chk(OFF_CNT2, 32'h00000002);
    rd_chk(OFF_CNT3, 32'h00050100);
    rd_chk(OFF_CNT6, 32'hff010000);
    $display("test counters done");
    // Injection toggles and field selects
    inj_step(32'h01, 6'h01);
    inj_step(32'h01, 6'h00);
    inj_step(32'h03, 6'h02);
    inj_step(32'h1b, 6'h18);
    inj_step(32'hffffffe4, 6'h1b);
    check_word("data select", 32'h3, {30'h0, inj_data_sel_o});
    rd_chk(OFF_INJECT, 32'h00000024);
    inj_step(32'h0, 6'h00);
    check_word("data select", 32'h0, {30'h0, inj_data_sel_o});
    $display("test inject done");
    // Non-leading port hides counters and ignores injection
    @(posedge clk_i);
    lead_port_i <= 1'b0;
    inj_step(32'h01, 6'h00);
    rd_chk(OFF_CNT6, 32'h0);
    rd_chk(OFF_INJECT, 32'h0);
    $display("test lead port done");
    conclude();
  end
endmodule // testbench
